// ==== bench/rcos_meas_model.sv ====
/* measurement partner: answers a closed check relay with one result pulse.
   assumes the bench sets the coil resistance and the answer lag. */
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////
module rcos_meas_model (
    input wire logic pclk, // bench clock
    input wire logic presetn, // async reset, low
    input wire logic check_relay, // circuit routed to measurement
    input wire logic [7:0] lag, // cycles until the answer
    input wire logic [15:0] res, // resistance of the coil
    output logic meas_done, // one-cycle result pulse
    output logic [15:0] meas_value // result, scrambled when idle
);
    logic [7:0] cnt_ff;
    // one answer per closing of the check relay
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 8'h00;
            meas_done <= 1'b0;
        end else begin
            meas_done <= check_relay && cnt_ff == lag;
            cnt_ff <= check_relay ? cnt_ff + 8'h01 : 8'h00;
        end
    end
    // value is only valid with the pulse
    assign meas_value = meas_done ? res : ~res;
endmodule : rcos_meas_model
`default_nettype wire

// ==== bench/relay_command_output_supervisor_bench.sv ====
/* bench for rcos_top: apb master, scoreboard and command scenarios.
   assumes rcos_meas_model stands in for the measurement circuit. */
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////
module relay_command_output_supervisor_bench;
    import rcos_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic coil = 1, sup = 1, sync = 0, err, pready, pslverr, chk_r, go, stb, alarm, led, irq;
    logic [31:0] paddr = 0, pwdata = 0, prdata, q;
    logic [7:0] relays, lag = 8'h14;
    logic [15:0] mval, res = 16'h0096;
    logic mdone;
    integer seed = 32'h390063c5;
    int n_errors = 0, comparisons = 0, exp;
    // 50 mhz clock
    always #10 pclk = ~pclk;
    rcos_top #(.TICK_CYCLES(10)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .coil_supply_ok(coil),
        .supply_supervision_input(sup), .time_sync_in(sync), .meas_done(mdone),
        .meas_value(mval), .command_relays(relays), .check_relay(chk_r), .go_relay(go),
        .setpoint_strobe(stb), .alarm_relay_output(alarm), .err_led(led), .irq(irq));
    rcos_meas_model pm (.pclk(pclk), .presetn(presetn), .check_relay(chk_r), .lag(lag),
        .res(res), .meas_done(mdone), .meas_value(mval));
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want) begin
            n_errors++;
            $display("MISMATCH %0t got %h want %h", $time, got, want);
        end
    endtask : chk
    // poll the state field until it shows s
    task automatic wait_state(input logic [5:0] s);
        q = 32'h0;
        for (int i = 0; i < 500 && q[5:0] !== s; i++) apb(1'b0, OFS_STATUS, 32'h0);
        chk(q[5:0], s);
    endtask : wait_state
    // one checked command, scored against the expected relay pattern
    task automatic run(input int c, input logic [1:0] pole, input logic ok, input logic drop);
        exp = (1 << c) | ((pole == P_TWO) << ((c + 1) % 8));
        res = ok ? 16'h0064 + 16'({$random(seed)} % 101) : 16'h0200;
        lag = ok ? 8'h14 : 8'h02;
        apb(1'b1, OFS_IRQ_STAT, 32'h3f);
        chk(irq, 1'b0);
        apb(1'b1, OFS_CTRL, {23'h0, 3'(c), 1'b1, pole, K_SINGLE});
        apb(1'b1, OFS_CMD, 32'h1);
        wait_state(6'h04);
        chk(relays, exp);
        apb(1'b1, OFS_CMD, 32'h1);
        apb(1'b1, OFS_CMD, 32'h2);
        if (ok) begin
            wait_state(6'h08);
            chk({chk_r, go}, 2'b10);
            wait_state(6'h20);
        end else wait_state(6'h01);
        chk({chk_r, go}, {1'b0, ok});
        chk(relays, ok ? exp : 0);
        coil <= ~drop;
        wait_state(6'h01);
        coil <= 1'b1;
        chk(relays, 0);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk(q & 32'h2f, ok ? (drop ? 32'h0d : 32'h29) : 32'h0a);
        chk(irq, 1'b1);
        $display("command test done on channel %0d", c);
    endtask : run
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // watchdog against a hung sequence
    initial begin
        #400_000;
        n_errors++;
        tally_and_finish();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, OFS_LIMIT, 32'h0);
        chk(q, RST_LIMIT);
        apb(1'b0, OFS_DUR, 32'h0);
        chk(q, {16'h0, RST_DUR});
        apb(1'b0, 8'h28, 32'h0);
        chk(q, 32'h0);
        chk(err, 1'b1);
        apb(1'b1, OFS_LIMIT, 32'h00c8_0064);
        apb(1'b1, OFS_DUR, 32'h5);
        apb(1'b1, OFS_IRQ_MASK, 32'h2f);
        apb(1'b1, OFS_CTRL, {23'h0, 3'h2, 1'b1, P_ONE, K_SINGLE});
        apb(1'b1, OFS_CMD, 32'h1);
        apb(1'b0, OFS_IRQ_STAT, 32'h0);
        chk({q[3], relays}, 9'h100);
        $display("register test done");
        for (int i = 0; i < 6; i++) run({$random(seed)} % 8, i[0] ? P_TWO : P_ONE_HALF, i != 2, i == 4);
        // strobed setpoint byte without check: relays follow the data byte
        exp = {$random(seed)} % 256;
        apb(1'b1, OFS_DATA, exp);
        apb(1'b1, OFS_CTRL, {23'h0, 3'h0, 1'b0, P_ONE, K_SETPT_STB});
        apb(1'b1, OFS_CMD, 32'h1);
        wait_state(6'h20);
        chk({stb, go, relays}, {2'b10, exp[7:0]});
        wait_state(6'h01);
        chk({stb, relays}, 9'h000);
        $display("setpoint test done");
        apb(1'b1, OFS_IRQ_MASK, 32'h0);
        chk(irq, 1'b0);
        apb(1'b1, OFS_CFG, 32'h0a);
        @(negedge pclk);
        chk({alarm, led}, 2'b11);
        @(posedge pclk);
        $display("alarm test done");
        tally_and_finish();
    end
endmodule : relay_command_output_supervisor_bench
`default_nettype wire

// ==== include/rcos_pkg.sv ====
/*
 * rcos_pkg: register map, field layout, enumerations and timing for the
 * relay command output supervisor.
 * assumes a 50 MHz pclk and a 32-bit apb master.
 */
`default_nettype none
package rcos_pkg;
    // apb byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_DATA = 8'h08;
    localparam logic [7:0] OFS_LIMIT = 8'h0c;
    localparam logic [7:0] OFS_DUR = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
    localparam logic [7:0] OFS_CFG = 8'h20;
    localparam logic [7:0] OFS_TIME = 8'h24;
    // command register bits (write one to act)
    localparam int CMD_START = 0;
    localparam int CMD_CHECK = 1;
    localparam int CMD_ABORT = 2;
    // config register bits
    localparam int CFG_SUP_EN = 0;
    localparam int CFG_ALARM_EN = 1;
    localparam int CFG_SYNC_EN = 2;
    localparam int CFG_UNIT_ERR = 3;
    localparam int CFG_UNIT_WARN = 4;
    // interrupt / sticky event bits
    localparam int EV_ACK = 0;
    localparam int EV_RES_FAIL = 1;
    localparam int EV_FAULT = 2;
    localparam int EV_REFUSED = 3;
    localparam int EV_SUP_CHG = 4;
    localparam int EV_DONE = 5;
    localparam int EV_W = 6;
    // reset values
    localparam logic [31:0] RST_LIMIT = 32'hffff_0000;
    localparam logic [15:0] RST_DUR = 16'h0064;
    // timing: clock rate, time base tick, supervision window
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int MS_PER_SEC = 1000;
    localparam int SUP_WIN_MS = 4000;
    localparam int CHECK_TMO_MS = 500;
    // edge count bands inside one window: 0.5 Hz gives 4, 2.0 Hz gives 16
    localparam logic [7:0] SLOW_MIN = 8'h03;
    localparam logic [7:0] SLOW_MAX = 8'h05;
    localparam logic [7:0] FAST_MIN = 8'h0d;
    localparam logic [7:0] FAST_MAX = 8'h13;
    // command kinds and pole modes
    typedef enum logic [2:0] {
        K_SINGLE = 3'h0, K_DOUBLE = 3'h1, K_REGSTEP = 3'h2, K_SETPT = 3'h3,
        K_SETPT_STB = 3'h4, K_BIT1 = 3'h5, K_BIT2 = 3'h6, K_BIT8 = 3'h7
    } rcos_kind_e;
    typedef enum logic [1:0] {
        P_ONE = 2'h0, P_ONE_HALF = 2'h1, P_TWO = 2'h2, P_BAD = 2'h3
    } rcos_pole_e;
    typedef enum logic [3:0] {
        SUP_NORMAL = 4'h1, SUP_MAINS = 4'h2, SUP_BATT = 4'h4, SUP_WIRING = 4'h8
    } rcos_sup_e;
    // control register layout
    typedef struct packed {
        logic [2:0] channel;
        logic check_en;
        rcos_pole_e pole;
        rcos_kind_e kind;
    } rcos_ctrl_s;
endpackage : rcos_pkg
`default_nettype wire

// ==== logic/rcos_top.sv ====
/*
 * rcos_top: command sequencer with resistance check, coil supply and
 * duration supervision, supply supervision decoder, time base, alarm and
 * error indicator, apb register file with interrupt.
 * assumes pins coil_supply_ok, supply_supervision_input and time_sync_in are
 * asynchronous; meas_done and meas_value come from logic on pclk.
 */
`timescale 1ns/10ps
`default_nettype none
module rcos_top #(
    parameter int TICK_CYCLES = rcos_pkg::TICK_CYC,
    parameter int MAX_DUR_MS = 60000
) (
    input wire logic pclk, // 50 MHz clock
    input wire logic presetn, // async reset, low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [31:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped
    input wire logic coil_supply_ok, // coil 24 v present pin
    input wire logic supply_supervision_input, // battery unit pin
    input wire logic time_sync_in, // external sync pulse pin
    input wire logic meas_done, // resistance result valid
    input wire logic [15:0] meas_value, // measured resistance
    output logic [7:0] command_relays, // interposing relay drives
    output logic check_relay, // route circuit to measurement
    output logic go_relay, // release selected relay
    output logic setpoint_strobe, // strobe for setpoint byte
    output logic alarm_relay_output, // alarm relay drive
    output logic err_led, // error indicator
    output logic irq // level interrupt
);
    import rcos_pkg::*;

    typedef enum logic [5:0] {
        S_IDLE = 6'h01, S_SUPCHK = 6'h02, S_SELECT = 6'h04,
        S_CHECK = 6'h08, S_SWBACK = 6'h10, S_OUTPUT = 6'h20
    } rcos_state_e;

    ////////////////////////////////////////////////////////////////////////
    // registers and signals
    rcos_ctrl_s ctrl_ff;
    logic [7:0] data_ff;
    logic [31:0] limit_ff;
    logic [15:0] dur_ff;
    logic [4:0] cfg_ff;
    logic [EV_W-1:0] irq_stat_ff, irq_mask_ff, ev;
    rcos_state_e state_ff, nxt_state;
    rcos_ctrl_s act_ff;
    logic [7:0] act_data_ff, mask_ff;
    logic [15:0] ms_in_state_ff;
    logic [2:0] coil_sync_ff, sup_sync_ff, ts_sync_ff;
    logic coil_ok, sup_lvl, sup_lvl_d_ff, ts_edge;
    logic [$clog2(TICK_CYCLES)-1:0] div_ff;
    logic ms_tick;
    logic [9:0] ms_ff;
    logic [21:0] sec_ff;
    logic [12:0] win_ff;
    logic [7:0] edges_ff;
    rcos_sup_e sup_state_ff, sup_new;
    logic wr, rd, mapped, cmd_start, cmd_check, cmd_abort;
    logic legal, fault, res_ok, cmd_err_ff, busy;

    // unmapped or aliased addresses neither write nor read
    assign mapped = paddr[1:0] == 2'h0 && paddr[31:8] == 24'h000000 && paddr[7:0] <= OFS_TIME;
    assign wr = psel && penable && pwrite && mapped;
    assign rd = psel && !pwrite && mapped;
    assign cmd_start = wr && paddr[7:0] == OFS_CMD && pwdata[CMD_START];
    assign cmd_check = wr && paddr[7:0] == OFS_CMD && pwdata[CMD_CHECK];
    assign cmd_abort = wr && paddr[7:0] == OFS_CMD && pwdata[CMD_ABORT];
    assign busy = state_ff != S_IDLE;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers, stage 0 read only by stage 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coil_sync_ff <= 3'h0;
            sup_sync_ff <= 3'h7; // idle level high, no false edge
            ts_sync_ff <= 3'h0;
        end else begin
            coil_sync_ff <= {coil_sync_ff[1:0], coil_supply_ok};
            sup_sync_ff <= {sup_sync_ff[1:0], supply_supervision_input};
            ts_sync_ff <= {ts_sync_ff[1:0], time_sync_in};
        end
    end
    assign coil_ok = coil_sync_ff[1];
    assign sup_lvl = sup_sync_ff[1];
    assign ts_edge = ts_sync_ff[1] && !ts_sync_ff[2];

    ////////////////////////////////////////////////////////////////////////
    // time base: millisecond enable, ms and seconds counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_ff <= '0;
        end else if (div_ff == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1)) begin
            div_ff <= '0;
        end else begin
            div_ff <= div_ff + 1'b1;
        end
    end
    assign ms_tick = div_ff == ($clog2(TICK_CYCLES))'(TICK_CYCLES - 1);

    // sync pulse realigns the millisecond phase to a second boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_ff <= 10'h000;
            sec_ff <= 22'h000000;
        end else if (cfg_ff[CFG_SYNC_EN] && ts_edge) begin
            ms_ff <= 10'h000;
            sec_ff <= sec_ff + 22'h000001;
        end else if (ms_tick) begin
            if (ms_ff == 10'(MS_PER_SEC - 1)) begin
                ms_ff <= 10'h000;
                sec_ff <= sec_ff + 22'h000001;
            end else begin
                ms_ff <= ms_ff + 10'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // supervision decoder: count edges over a window, classify by band
    always_comb begin
        if (edges_ff >= SLOW_MIN && edges_ff <= SLOW_MAX) begin
            sup_new = SUP_MAINS;
        end else if (edges_ff >= FAST_MIN && edges_ff <= FAST_MAX) begin
            sup_new = SUP_BATT;
        end else if (edges_ff == 8'h00 && sup_lvl) begin
            sup_new = SUP_NORMAL;
        end else begin
            sup_new = SUP_WIRING;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sup_lvl_d_ff <= 1'b1; // matches synchroniser reset
            win_ff <= 13'h0000;
            edges_ff <= 8'h00;
            sup_state_ff <= SUP_NORMAL;
        end else begin
            sup_lvl_d_ff <= sup_lvl;
            if (ms_tick && win_ff == 13'(SUP_WIN_MS - 1)) begin
                win_ff <= 13'h0000;
                edges_ff <= 8'h00;
                sup_state_ff <= sup_new;
            end else begin
                if (ms_tick) begin
                    win_ff <= win_ff + 13'h0001;
                end
                if (sup_lvl != sup_lvl_d_ff && edges_ff != 8'hff) begin
                    edges_ff <= edges_ff + 8'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // relay pattern for a command
    function automatic logic [7:0] relay_mask(input rcos_ctrl_s c, input logic [7:0] d);
        logic [7:0] one;
        logic [2:0] sel;
        one = 8'h01;
        sel = c.channel + {2'h0, d[0]};
        relay_mask = 8'h00;
        unique case (c.kind)
            K_SINGLE: begin
                relay_mask = one << c.channel;
                if (c.pole == P_TWO) begin
                    relay_mask = relay_mask | (one << 3'(c.channel + 3'h1));
                end
            end
            K_DOUBLE, K_REGSTEP: begin
                relay_mask = one << sel;
                if (c.pole == P_TWO) begin
                    relay_mask = relay_mask | (one << 3'(sel + 3'h2));
                end
            end
            K_SETPT, K_SETPT_STB, K_BIT8: relay_mask = d;
            K_BIT1: relay_mask = {7'h00, d[0]} << c.channel;
            K_BIT2: relay_mask = {6'h00, d[1:0]} << c.channel;
        endcase
    endfunction

    // pole modes: 1.5 only with check, 1 only without, check only on single and double commands
    always_comb begin
        legal = 1'b1;
        if (ctrl_ff.pole == P_BAD) begin
            legal = 1'b0;
        end else if (ctrl_ff.check_en) begin
            legal = (ctrl_ff.kind == K_SINGLE || ctrl_ff.kind == K_DOUBLE)
                && ctrl_ff.pole != P_ONE;
        end else if (ctrl_ff.pole == P_ONE_HALF) begin
            legal = 1'b0;
        end
        if (dur_ff == 16'h0000 || 32'(dur_ff) > MAX_DUR_MS) begin
            legal = 1'b0;
        end
    end

    assign res_ok = meas_value >= limit_ff[15:0] && meas_value <= limit_ff[31:16];
    // monitoring faults while a command is active
    assign fault = busy && state_ff != S_SUPCHK && (!coil_ok
        || (state_ff == S_OUTPUT && ms_in_state_ff > dur_ff)
        || (state_ff == S_CHECK && ms_in_state_ff >= 16'(CHECK_TMO_MS)));

    ////////////////////////////////////////////////////////////////////////
    // command sequencer
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            S_IDLE: if (cmd_start && legal) nxt_state = S_SUPCHK;
            S_SUPCHK: begin
                if (!coil_ok) nxt_state = S_IDLE;
                else if (act_ff.check_en) nxt_state = S_SELECT;
                else nxt_state = S_OUTPUT;
            end
            S_SELECT: if (cmd_check) nxt_state = S_CHECK;
            S_CHECK: begin
                if (meas_done && res_ok) nxt_state = S_SWBACK;
                else if (meas_done) nxt_state = S_IDLE;
            end
            S_SWBACK: nxt_state = S_OUTPUT;
            S_OUTPUT: if (ms_tick && ms_in_state_ff == dur_ff - 16'h0001) nxt_state = S_IDLE;
        endcase
        if (fault || cmd_abort) begin
            nxt_state = S_IDLE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= S_IDLE;
            act_ff <= '0;
            act_data_ff <= 8'h00;
            mask_ff <= 8'h00;
            ms_in_state_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == S_IDLE && cmd_start && legal) begin
                act_ff <= ctrl_ff;
                act_data_ff <= data_ff;
                mask_ff <= relay_mask(ctrl_ff, data_ff);
            end
            if (nxt_state != state_ff) begin
                ms_in_state_ff <= 16'h0000;
            end else if (ms_tick && ms_in_state_ff != 16'hffff) begin
                ms_in_state_ff <= ms_in_state_ff + 16'h0001;
            end
        end
    end

    // relay drives registered from the next state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command_relays <= 8'h00;
            check_relay <= 1'b0;
            go_relay <= 1'b0;
            setpoint_strobe <= 1'b0;
        end else begin
            command_relays <= (nxt_state == S_OUTPUT
                || (nxt_state & (S_SELECT | S_CHECK | S_SWBACK)) != 6'h00)
                ? mask_ff : 8'h00;
            check_relay <= nxt_state == S_CHECK;
            go_relay <= nxt_state == S_OUTPUT && act_ff.check_en;
            setpoint_strobe <= nxt_state == S_OUTPUT && act_ff.kind == K_SETPT_STB;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // events, sticky status, unit error
    always_comb begin
        ev = '0;
        ev[EV_ACK] = state_ff == S_CHECK && meas_done && res_ok && !fault;
        ev[EV_RES_FAIL] = state_ff == S_CHECK && meas_done && !res_ok;
        ev[EV_FAULT] = fault || (state_ff == S_SUPCHK && !coil_ok);
        ev[EV_REFUSED] = cmd_start && (busy || !legal);
        ev[EV_SUP_CHG] = cfg_ff[CFG_SUP_EN] && ms_tick
            && win_ff == 13'(SUP_WIN_MS - 1) && sup_new != sup_state_ff;
        ev[EV_DONE] = state_ff == S_OUTPUT && nxt_state == S_IDLE && !fault && !cmd_abort;
    end

    // command error stays until the next accepted command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_err_ff <= 1'b0;
        end else if (ev[EV_FAULT] || ev[EV_RES_FAIL]) begin
            cmd_err_ff <= 1'b1;
        end else if (state_ff == S_IDLE && nxt_state == S_SUPCHK) begin
            cmd_err_ff <= 1'b0;
        end
    end

    // abnormal supervision: mains is a warning, battery and wiring are errors
    logic unit_err, unit_warn;
    assign unit_err = cfg_ff[CFG_UNIT_ERR] || cmd_err_ff || (cfg_ff[CFG_SUP_EN]
        && (sup_state_ff == SUP_BATT || sup_state_ff == SUP_WIRING));
    assign unit_warn = cfg_ff[CFG_UNIT_WARN]
        || (cfg_ff[CFG_SUP_EN] && sup_state_ff == SUP_MAINS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_relay_output <= 1'b0;
            err_led <= 1'b0;
        end else begin
            alarm_relay_output <= cfg_ff[CFG_ALARM_EN] && unit_err;
            err_led <= unit_err || (unit_warn && ms_ff[9]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb register file
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= '0;
            data_ff <= 8'h00;
            limit_ff <= RST_LIMIT;
            dur_ff <= RST_DUR;
            cfg_ff <= 5'h00;
            irq_mask_ff <= '0;
        end else if (wr) begin
            unique case (paddr[7:0])
                OFS_CTRL: ctrl_ff <= pwdata[8:0];
                OFS_DATA: data_ff <= pwdata[7:0];
                OFS_LIMIT: limit_ff <= pwdata;
                OFS_DUR: dur_ff <= pwdata[15:0];
                OFS_CFG: cfg_ff <= pwdata[4:0];
                OFS_IRQ_MASK: irq_mask_ff <= pwdata[EV_W-1:0];
                default: ;
            endcase
        end
    end

    // sticky events, write one clears, a new event wins over the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_ff <= '0;
        end else if (wr && paddr[7:0] == OFS_IRQ_STAT) begin
            irq_stat_ff <= (irq_stat_ff & ~pwdata[EV_W-1:0]) | ev;
        end else begin
            irq_stat_ff <= irq_stat_ff | ev;
        end
    end
    assign irq = |(irq_stat_ff & irq_mask_ff);

    always_comb begin
        prdata = 32'h0000_0000;
        if (rd) begin
            unique case (paddr[7:0])
                OFS_CTRL: prdata = {23'h000000, ctrl_ff};
                OFS_DATA: prdata = {24'h000000, data_ff};
                OFS_LIMIT: prdata = limit_ff;
                OFS_DUR: prdata = {16'h0000, dur_ff};
                OFS_STATUS: prdata = {16'h0000, 3'h0, cmd_err_ff, sup_state_ff,
                    2'h0, state_ff};
                OFS_IRQ_STAT: prdata = {26'h0000000, irq_stat_ff};
                OFS_IRQ_MASK: prdata = {26'h0000000, irq_mask_ff};
                OFS_CFG: prdata = {27'h0000000, cfg_ff};
                OFS_TIME: prdata = {sec_ff, cfg_ff[CFG_SYNC_EN] ? ms_ff : 10'h000};
                default: prdata = 32'h0000_0000;
            endcase
        end
    end
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    check_go_excl_a: assert property (!(check_relay && go_relay))
        else $error("check and go relay on together");
    swback_gap_a: assert property ($rose(go_relay) && act_ff.check_en
        |-> !$past(check_relay))
        else $error("go relay rose while check relay on");
    check_order_a: assert property (state_ff == S_SELECT && cmd_check && !fault && !cmd_abort
        |=> check_relay)
        else $error("check order did not energise check relay");
    res_fail_a: assert property (state_ff == S_CHECK && meas_done && !res_ok
        |=> !go_relay && state_ff == S_IDLE ##1 command_relays == 8'h00)
        else $error("failed resistance did not block output");
    res_pass_a: assert property (state_ff == S_CHECK && meas_done && res_ok && !fault
        && !cmd_abort |=> irq_stat_ff[EV_ACK] ##1 go_relay)
        else $error("passed check not acknowledged and released");
    coil_cancel_a: assert property (busy && state_ff != S_SUPCHK && !coil_ok
        |=> state_ff == S_IDLE ##1 command_relays == 8'h00)
        else $error("coil loss did not cancel command");
    fault_flag_a: assert property (fault |=> irq_stat_ff[EV_FAULT] && cmd_err_ff)
        else $error("fault not reported");
    refuse_busy_a: assert property (busy && cmd_start |=> $stable(act_ff)
        && irq_stat_ff[EV_REFUSED])
        else $error("command taken while busy");
    two_pole_a: assert property (state_ff == S_OUTPUT && act_ff.kind == K_SINGLE
        && act_ff.pole == P_TWO |-> $countones(command_relays) == 2)
        else $error("two pole command not on two relays");
    alarm_a: assert property (cfg_ff[CFG_ALARM_EN] && cmd_err_ff |=> alarm_relay_output)
        else $error("alarm relay not driven on error");
    led_a: assert property (unit_err |=> err_led)
        else $error("error led not steady in error");
    strobe_a: assert property (setpoint_strobe |-> act_ff.kind == K_SETPT_STB
        && state_ff == S_OUTPUT)
        else $error("strobe outside strobed setpoint output");
endmodule : rcos_top
`default_nettype wire
